// *** rtl/dhp_host_port.sv ***
// Host port of the display module: 6800, 8080 and serial transports
`default_nettype none

module dhp_host_port
  import dhp_pkg::*;
(
  // System clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   sys_rst,
  // Host control pins
  input  wire logic                   host_cs_n,
  input  wire logic                   host_dc,
  input  wire logic                   host_rw_wr_n,
  input  wire logic                   host_en_rd,
  input  wire logic                   init_in_n,
  input  wire logic [1:0]             bus_protocol_strap,
  // Host data bus, split into its three signals
  input  wire logic [DHP_BUS_W-1:0]   host_data_bus_in,
  output var  logic [DHP_BUS_W-1:0]   host_data_bus_out,
  output var  logic                   host_data_bus_oe_n,
  // Serial clock, the bus line zero wired as a clock
  input  wire logic                   serial_clk,
  // Received bytes toward the display core
  output var  dhp_pkg::dhp_byte_type  rx,
  output var  logic                   rx_valid,
  output var  logic                   cmd_strobe,
  output var  logic                   data_strobe,
  // Read requests and read data from the display core
  output var  logic                   rd_req,
  output var  logic                   rd_is_data,
  input  wire logic [DHP_BUS_W-1:0]   rd_value,
  // Transport in use
  output var  dhp_pkg::dhp_mode_type  mode
);
  import dhp_pkg::*;

  // Whole state of the system-clock side
  typedef struct packed {
    // Two synchroniser stages for every host pin
    dhp_pins_type            pin_meta;
    dhp_pins_type            pin_sync;

    // Serial hand-off toggle history and strap settling count
    logic [2:0]              tog;
    logic [DHP_SETTLE_W-1:0] settle;

    // Transport and parallel cycle phase
    dhp_mode_type            mode;
    dhp_phase_type           phase;

    // Write capture and read drive toward the pins
    dhp_byte_type            wr_hold;
    logic [DHP_BUS_W-1:0]    dout;
    logic                    oe_n;

    // Byte hand-off and read request toward the core
    dhp_byte_type            rx;
    logic                    rx_valid;
    logic                    cmd_strobe;
    logic                    data_strobe;
    logic                    rd_req;
    logic                    rd_is_data;
  } dhp_state_type;

  localparam dhp_state_type DHP_STATE_RESET = '{
    // Pins rest deselected, so no false cycle follows reset
    pin_meta:    DHP_PINS_IDLE,
    pin_sync:    DHP_PINS_IDLE,
    // Toggle history matches the receiver's reset level
    tog:         3'h0,
    settle:      3'h0,
    // 6800 until the first edge, then SPI4 from the idle pin view until the strap has been read through the synchroniser
    mode:        DHP_MODE_M6800,
    phase:       DHP_IDLE,
    wr_hold:     DHP_BYTE_ZERO,
    // Bus released
    dout:        DHP_DATA_ZERO,
    oe_n:        1'h1,
    // Nothing delivered yet
    rx:          DHP_BYTE_ZERO,
    rx_valid:    1'h0,
    cmd_strobe:  1'h0,
    data_strobe: 1'h0,
    rd_req:      1'h0,
    rd_is_data:  1'h0
  };

  dhp_state_type state;
  dhp_state_type next_state;

  dhp_pins_type pins_now;
  dhp_byte_type ser_word;
  logic         ser_toggle;
  logic         frame_rst;

  // Strap decode into a transport
  function automatic dhp_mode_type strap_mode(input logic [1:0] strap);
    dhp_mode_type m;
    m = DHP_MODE_M6800;
    unique case (strap)
      DHP_STRAP_SPI4:  m = DHP_MODE_SPI4;
      DHP_STRAP_SPI3:  m = DHP_MODE_SPI3;
      DHP_STRAP_I8080: m = DHP_MODE_I8080;
      default:         m = DHP_MODE_M6800;
    endcase
    return m;
  endfunction

  // Gather the raw pins for the synchroniser
  always_comb begin
    pins_now         = DHP_PINS_IDLE;
    pins_now.cs_n    = host_cs_n;
    pins_now.dc      = host_dc;
    pins_now.rw_wr_n = host_rw_wr_n;
    pins_now.en_rd   = host_en_rd;
    pins_now.init_n  = init_in_n;
    pins_now.strap   = bus_protocol_strap;
    pins_now.data    = host_data_bus_in;
  end

  // Serial frame ends when chip select rises; the pin resets it directly
  // because the serial clock stands still outside frames.
  // Limitation: a select glitch shorter than one serial bit cuts the frame.
  assign frame_rst = sys_rst | host_cs_n;

  // Serial receiver on the link clock
  dhp_serial_rx u_serial_rx (
    .serial_clk     (serial_clk),
    .frame_rst      (frame_rst),
    .sys_rst        (sys_rst),
    .serial_data_in (host_data_bus_in[1]),
    .dc_level       (host_dc),
    .word           (ser_word),
    .word_toggle    (ser_toggle)
  );

  // Latency: pins reach this logic two edges late, so a parallel strobe
  // must stand for at least one system clock to be seen at all. A write
  // is taken from the last synced active cycle and delivered one edge
  // after its end is seen; slow hosts were traded for a single clock.
  // Next-state logic
  always_comb begin
    // Synced pin view and transport qualifiers
    dhp_pins_type p;
    logic         sel;
    logic         par;
    logic         m68;
    // Parallel cycle decode
    logic         cyc_on;
    logic         want_rd;
    // Delivery path
    logic         ser_evt;
    logic         deliver;
    dhp_byte_type got;

    next_state             = state;
    next_state.rx_valid    = 1'h0;
    next_state.cmd_strobe  = 1'h0;
    next_state.data_strobe = 1'h0;
    next_state.rd_req      = 1'h0;
    deliver                = 1'h0;
    got                    = state.wr_hold;

    // Every local starts from a safe value, so no path leaves one unset
    p                      = DHP_PINS_IDLE;
    sel                    = 1'h0;
    par                    = 1'h0;
    m68                    = 1'h0;
    cyc_on                 = 1'h0;
    want_rd                = 1'h0;
    ser_evt                = 1'h0;

    // Two flops per pin; only the second stage is read below
    next_state.pin_meta = pins_now;
    next_state.pin_sync = state.pin_meta;
    next_state.tog      = {state.tog[1:0], ser_toggle};
    next_state.settle   = {state.settle[DHP_SETTLE_W-2:0], 1'h1};

    p       = state.pin_sync;
    sel     = ~p.cs_n;
    m68     = state.mode == DHP_MODE_M6800;
    par     = m68 || state.mode == DHP_MODE_I8080;
    ser_evt = state.tog[2] ^ state.tog[1];

    // A 6800 cycle is enable high under select; 8080 is either strobe low
    if (m68) begin
      cyc_on  = sel & p.en_rd;
      want_rd = p.rw_wr_n;
    end else begin
      cyc_on  = sel & (~p.rw_wr_n | ~p.en_rd);
      want_rd = ~p.en_rd & p.rw_wr_n;
    end

    // Parallel cycle sequencing
    unique case (state.phase)
      DHP_IDLE: begin
        // A read drives at once; a write waits for its strobe to end
        if (par && cyc_on) begin
          if (want_rd) begin
            next_state.phase      = DHP_READ;
            next_state.dout       = rd_value;
            next_state.oe_n       = 1'h0;
            next_state.rd_req     = 1'h1;
            next_state.rd_is_data = p.dc;
          end else begin
            next_state.phase   = DHP_WRITE;
            next_state.wr_hold = '{is_data: p.dc, value: p.data};
          end
        end
      end
      DHP_WRITE: begin
        // Keep the latest bus value; it is taken when the strobe ends
        if (cyc_on) begin
          next_state.wr_hold = '{is_data: p.dc, value: p.data};
        end else begin
          next_state.phase = DHP_IDLE;
          deliver          = 1'h1;
          got              = state.wr_hold;
        end
      end
      DHP_READ: begin
        // Bus released as soon as the read strobe or select goes away
        if (!cyc_on) begin
          next_state.phase = DHP_IDLE;
          next_state.oe_n  = 1'h1;
        end
      end
      default: begin
        // Code 3 is never entered; fall back to an idle, released bus
        next_state.phase = DHP_IDLE;
        next_state.oe_n  = 1'h1;
      end
    endcase

    // Serial bytes arrive by toggle; words stay stable eight clocks
    // The toggle passed two flops, so the word has long settled here
    if (!par && ser_evt) begin
      deliver = 1'h1;
      got     = ser_word;
    end

    // Hand the byte to the core with its class
    if (deliver) begin
      next_state.rx          = got;
      next_state.rx_valid    = 1'h1;
      next_state.data_strobe = got.is_data;
      next_state.cmd_strobe  = ~got.is_data;
    end

    // Init pin low, or strap not yet settled: reload transport, go idle
    // The serial receiver is left alone; chip select drops a cut byte
    if (!p.init_n || !state.settle[DHP_SETTLE_W-1]) begin
      next_state.mode        = strap_mode(p.strap);
      next_state.phase       = DHP_IDLE;
      next_state.oe_n        = 1'h1;
      next_state.rx_valid    = 1'h0;
      next_state.cmd_strobe  = 1'h0;
      next_state.data_strobe = 1'h0;
      next_state.rd_req      = 1'h0;
    end
  end

  // State register
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= DHP_STATE_RESET;
    end else begin
      state <= next_state;
    end
  end

  // Bus drive straight from the state register
  assign host_data_bus_out  = state.dout;
  assign host_data_bus_oe_n = state.oe_n;

  // Byte hand-off and read request, all from flops
  assign rx                 = state.rx;
  assign rx_valid           = state.rx_valid;
  assign cmd_strobe         = state.cmd_strobe;
  assign data_strobe        = state.data_strobe;
  assign rd_req             = state.rd_req;
  assign rd_is_data         = state.rd_is_data;

  // Transport in use, for the core's own decoding
  assign mode               = state.mode;

endmodule

`default_nettype wire

// *** rtl/dhp_pkg.sv ***
// Shared constants and types for the display host port
`default_nettype none

package dhp_pkg;

  // Host data bus width
  localparam int DHP_BUS_W = 8;

  // Strap codes picking the transport; the remaining code is 6800 style
  localparam logic [1:0] DHP_STRAP_SPI4  = 2'h0;
  localparam logic [1:0] DHP_STRAP_SPI3  = 2'h1;
  localparam logic [1:0] DHP_STRAP_I8080 = 2'h2;

  // Serial byte framing: bit indices of the first and last bit of a byte
  localparam logic [2:0] DHP_BIT_FIRST = 3'h0;
  localparam logic [2:0] DHP_BIT_LAST  = 3'h7;

  // Cycles after reset before the strap is trusted (two sync stages plus the mode load)
  localparam int DHP_SETTLE_W = 3;

  // Transport chosen by the strap
  typedef enum logic [1:0] {
    DHP_MODE_SPI4,
    DHP_MODE_SPI3,
    DHP_MODE_I8080,
    DHP_MODE_M6800
  } dhp_mode_type;

  // Parallel cycle phase
  typedef enum logic [1:0] {
    DHP_IDLE,
    DHP_WRITE,
    DHP_READ
  } dhp_phase_type;

  // One received byte with its data/command class
  typedef struct packed {
    logic                 is_data;
    logic [DHP_BUS_W-1:0] value;
  } dhp_byte_type;

  // Host pins as seen through the synchroniser
  typedef struct packed {
    logic                 cs_n;
    logic                 dc;
    logic                 rw_wr_n;
    logic                 en_rd;
    logic                 init_n;
    logic [1:0]           strap;
    logic [DHP_BUS_W-1:0] data;
  } dhp_pins_type;

  // Reset values
  localparam logic [DHP_BUS_W-1:0] DHP_DATA_ZERO = 8'h00;
  localparam dhp_byte_type DHP_BYTE_ZERO = '{
    is_data: 1'h0,
    value:   8'h00
  };
  localparam dhp_pins_type DHP_PINS_IDLE = '{
    cs_n:    1'h1,
    dc:      1'h0,
    rw_wr_n: 1'h0,
    en_rd:   1'h0,
    init_n:  1'h1,
    strap:   2'h0,
    data:    8'h00
  };

endpackage

`default_nettype wire

// *** rtl/dhp_serial_rx.sv ***
// Serial byte receiver clocked by the host's serial clock line
`default_nettype none

module dhp_serial_rx
  import dhp_pkg::*;
(
  // Link clock and resets
  input  wire logic           serial_clk,
  input  wire logic           frame_rst,
  input  wire logic           sys_rst,
  // Serial line and class level
  input  wire logic           serial_data_in,
  input  wire logic           dc_level,
  // Hand-off to the system domain
  output var  dhp_pkg::dhp_byte_type word,
  output var  logic           word_toggle
);
  import dhp_pkg::*;

  typedef struct packed {
    logic [2:0] count;
    logic [6:0] shift;
  } dhp_frame_type;

  typedef struct packed {
    dhp_byte_type word;
    logic         toggle;
  } dhp_handoff_type;

  dhp_frame_type   frame;
  dhp_frame_type   next_frame;
  dhp_handoff_type handoff;
  dhp_handoff_type next_handoff;

  // Shift in MSB first; eighth bit closes the byte with its class level
  always_comb begin
    next_frame       = frame;
    next_handoff     = handoff;
    next_frame.count = frame.count + 3'h1;
    next_frame.shift = {frame.shift[5:0], serial_data_in};
    if (frame.count == DHP_BIT_LAST) begin
      next_handoff.word.value   = {frame.shift, serial_data_in};
      next_handoff.word.is_data = dc_level;
      next_handoff.toggle       = ~handoff.toggle;
    end
  end

  // Frame state dies with chip select, so a partial byte is dropped
  always_ff @(posedge serial_clk or posedge frame_rst) begin
    if (frame_rst) begin
      frame <= '{count: DHP_BIT_FIRST, shift: 7'h00};
    end else begin
      frame <= next_frame;
    end
  end

  // Hand-off survives chip select so no false toggle edge appears
  always_ff @(posedge serial_clk or posedge sys_rst) begin
    if (sys_rst) begin
      handoff <= '{word: DHP_BYTE_ZERO, toggle: 1'h0};
    end else begin
      handoff <= next_handoff;
    end
  end

  assign word        = handoff.word;
  assign word_toggle = handoff.toggle;

endmodule

`default_nettype wire

// *** tb/dhp_host_model.sv ***
// Host microcontroller model for the parallel and serial transports
`default_nettype none
module dhp_host_model (
  // Timing reference
  input wire logic       sys_clk,
  // Pins toward the device; dq bit 0 is the serial clock
  output var logic       cs_n,
  output var logic       dc,
  output var logic       rw_wr_n,
  output var logic       en_rd,
  output var logic [7:0] dq,
  // Resolved bus level
  input wire logic [7:0] bus
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle levels; a released bus shows the inverse so no stale value lingers, bit 0 held low in serial modes
  task automatic idle(input logic [1:0] m);
    cs_n    = 1'b1;
    rw_wr_n = m[1];
    en_rd   = m == 2'h2;
    dq      = {~dq[7:1], m[1] & ~dq[0]};
  endtask
  initial begin
    dq = 8'h00;
    dc = 1'b0;
    idle(2'h3);
  end
  // One parallel cycle; strobes are slow since the device samples them
  task automatic cyc(input logic [1:0] m, input logic sel, rd, d_c,
                     input logic [7:0] b, output logic [7:0] got);
    @(posedge sys_clk) #2;
    cs_n    = ~sel;
    dc      = d_c;
    dq      = rd ? ~b : b;
    rw_wr_n = rd;
    en_rd   = m[0] | ~rd;
    repeat (5) @(posedge sys_clk);
    #2 got  = bus;
    en_rd   = ~m[0];
    rw_wr_n = rw_wr_n | ~m[0];
    repeat (3) @(posedge sys_clk);
    #2 idle(m);
    repeat (4) @(posedge sys_clk);
    #2;
  endtask
  // Serial frame of n bits, MSB first; the clock rests low between frames
  task automatic ser(input logic d_c, input logic [7:0] b, input int n);
    #($urandom_range(37, 3));
    cs_n = 1'b0;
    dc   = d_c;
    for (int i = 7; i > 7 - n; i--) begin
      dq[1] = b[i];
      #80 dq[0] = 1'b1;
      #80 dq[0] = 1'b0;
    end
    #80 idle(2'h0);
    #400;
  endtask
endmodule
`default_nettype wire

// *** tb/dhp_host_port_asserts.sv ***
// Checker for the display host port, bound to its top module
`default_nettype none
module dhp_host_port_asserts
  import dhp_pkg::*;
(
  // Clock and reset
  input wire logic                  sys_clk,
  input wire logic                  sys_rst,
  // Host pins
  input wire logic                  host_cs_n,
  input wire logic                  host_rw_wr_n,
  input wire logic                  host_en_rd,
  input wire logic                  init_in_n,
  input wire logic [1:0]            bus_protocol_strap,
  // Bus and core side
  input wire logic [DHP_BUS_W-1:0]  host_data_bus_out,
  input wire logic                  host_data_bus_oe_n,
  input wire dhp_pkg::dhp_byte_type rx,
  input wire logic                  rx_valid,
  input wire logic                  cmd_strobe,
  input wire logic                  data_strobe,
  input wire logic                  rd_req,
  input wire logic [DHP_BUS_W-1:0]  rd_value,
  input wire dhp_pkg::dhp_mode_type mode
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // Byte class and delivery pulses
  data_class_a: assert property (
    rx_valid |-> data_strobe == rx.is_data && cmd_strobe == !rx.is_data)
    else $error("class strobe wrong");
  strobe_only_a: assert property (
    (cmd_strobe || data_strobe) |-> rx_valid) else $error("stray strobe");
  pulse_once_a: assert property (
    rx_valid |=> !rx_valid) else $error("byte pulse too long");
  // Deselected or held in init, nothing happens
  cs_gate_a: assert property (
    host_cs_n [*6] |-> !rx_valid && !rd_req) else $error("activity unselected");
  init_hold_a: assert property (
    (!init_in_n) [*4] |-> host_data_bus_oe_n && !rx_valid && !rd_req)
    else $error("activity during init");
  // Bus is driven only by parallel reads
  bus_drive_a: assert property (
    !host_data_bus_oe_n |-> mode inside {DHP_MODE_I8080, DHP_MODE_M6800})
    else $error("bus driven in serial mode");
  read_data_a: assert property (
    rd_req |-> !host_data_bus_oe_n && host_data_bus_out == $past(rd_value))
    else $error("read data wrong");
  rd_start_a: assert property (
    $fell(host_en_rd) && host_rw_wr_n && !host_cs_n && init_in_n
    && mode == DHP_MODE_I8080 |-> ##[1:4] rd_req) else $error("read missed");
  wr_6800_a: assert property (
    $fell(host_en_rd) && !host_rw_wr_n && !host_cs_n && init_in_n
    && mode == DHP_MODE_M6800 |-> ##[1:5] rx_valid) else $error("write missed");
  wr_8080_a: assert property (
    $rose(host_rw_wr_n) && host_en_rd && !host_cs_n && init_in_n
    && mode == DHP_MODE_I8080 |-> ##[1:5] rx_valid) else $error("write lost");
  strap_mode_a: assert property (
    $stable(bus_protocol_strap) [*5] |->
    mode == dhp_mode_type'(bus_protocol_strap)) else $error("mode mismatch");
endmodule
`default_nettype wire

// *** tb/dhp_host_port_bench.sv ***
// Self-checking bench for the display host port
`default_nettype none
module dhp_host_port_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import dhp_pkg::*;
  logic         sys_clk = 1'b0;
  logic         sys_rst = 1'b1;
  logic         init_in_n = 1'b1;
  logic [1:0]   strap = 2'h3;
  logic [7:0]   rd_value = 8'h00;
  logic [7:0]   bus, dq, out, got, b;
  logic         cs_n, dc, rw, en, oe_n, rx_valid, cmd_s, data_s, c;
  logic         rd_req, rd_is_data;
  dhp_byte_type rx;
  dhp_mode_type mode;
  int           error_cnt = 0;
  int           checked = 0;
  logic [8:0]   exp_q[$];

  always #20 sys_clk = ~sys_clk;
  // Device owns the bus only while its enable is low
  assign bus = oe_n === 1'b0 ? out : dq;

  dhp_host_port dut_u (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .host_cs_n(cs_n), .host_dc(dc),
    .host_rw_wr_n(rw), .host_en_rd(en), .init_in_n(init_in_n),
    .bus_protocol_strap(strap), .host_data_bus_in(bus),
    .host_data_bus_out(out), .host_data_bus_oe_n(oe_n),
    .serial_clk(bus[0]), .rx(rx), .rx_valid(rx_valid),
    .cmd_strobe(cmd_s), .data_strobe(data_s), .rd_req(rd_req),
    .rd_is_data(rd_is_data), .rd_value(rd_value), .mode(mode));
  dhp_host_model host_u (
    .sys_clk(sys_clk), .cs_n(cs_n), .dc(dc), .rw_wr_n(rw), .en_rd(en),
    .dq(dq), .bus(bus));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    if (error_cnt == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Each delivered byte must be the oldest one still owed
  always @(posedge sys_clk) begin
    if (rx_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk(16'h0001, 16'h0000);
      end else begin
        chk({rx, cmd_s, data_s},
            {exp_q[0], ~exp_q[0][8], exp_q[0][8]});
        void'(exp_q.pop_front());
      end
    end
  end

  // Walk all four transports: writes, a refused one, then a read on the parallel ones
  initial begin
    void'($urandom(32'hd206));
    for (int m = 0; m < 4; m++) begin
      #2;
      strap   = 2'(m);
      sys_rst = 1'b1;
      host_u.idle(strap);
      repeat (12) @(posedge sys_clk);
      #2 sys_rst = 1'b0;
      repeat (5) @(posedge sys_clk);
      chk(16'(mode), 16'(m));
      for (int k = 0; k < 5; k++) begin
        b = 8'($urandom);
        c = 1'($urandom);
        if (k < 4) exp_q.push_back({c, b});
        if (m > 1) host_u.cyc(strap, k < 4, 1'b0, c, b, got);
        else host_u.ser(c, b, k < 4 ? 8 : 5);
      end
      if (m > 1) begin
        rd_value = 8'($urandom);
        host_u.cyc(strap, 1'b1, 1'b1, c, 8'h00, got);
        chk({rd_is_data, got}, {c, rd_value});
        chk(16'(oe_n), 16'h0001);
      end
      repeat (10) @(posedge sys_clk);
      chk(16'(exp_q.size()), 16'h0000);
    end
    // Init held low swallows a write; traffic resumes after it
    #2 init_in_n = 1'b0;
    repeat (4) @(posedge sys_clk);
    host_u.cyc(strap, 1'b1, 1'b0, 1'b1, 8'h5a, got);
    init_in_n = 1'b1;
    exp_q.push_back(9'h1a5);
    host_u.cyc(strap, 1'b1, 1'b0, 1'b1, 8'ha5, got);
    repeat (10) @(posedge sys_clk);
    chk(16'(exp_q.size()), 16'h0000);
    wrap_up();
  end

  // A hang counts as a mismatch
  initial begin
    repeat (60000) @(posedge sys_clk);
    error_cnt++;
    wrap_up();
  end
endmodule

bind dhp_host_port dhp_host_port_asserts chk_u (.*);
`default_nettype wire
